// ---- common/svg_pkg.sv ----
package svg_pkg;
  // timing base
  localparam int unsigned CLK_MHZ          = 100;     // block clock rate
  localparam int unsigned DIS_DELAY_NS     = 15000;   // power-down disable delay, 15 us
  localparam int unsigned DIS_DELAY_CYC    = (DIS_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RST_TIMEOUT_MS   = 200;     // reset timeout after supply recovers
  localparam int unsigned RST_TIMEOUT_CYC  = RST_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int unsigned CNT_W            = 25;      // wide enough for the reset timeout
  localparam int unsigned DIS_CNT_W        = 12;      // wide enough for the disable delay
  // comparator thresholds as documented, in millivolts, for reference only
  localparam int unsigned FAIL_THRESH_MV   = 1250;    // fail sense trip point
  localparam int unsigned BACKUP_MARGIN_MV = 1200;    // fail compare stays live above battery minus this

  // chip-enable gate states
  typedef enum logic [2:0] {
    SVG_GATE_PASS = 3'b001,  // transmission path on
    SVG_GATE_WAIT = 3'b010,  // reset asserted, waiting for select high or delay
    SVG_GATE_OFF  = 3'b100   // path off, output pulled high
  } svg_gate_t;
endpackage : svg_pkg

// ---- core/svg_ctrl.sv ----
`timescale 1ns/1ps
module svg_ctrl #(
  parameter int unsigned RST_TIMEOUT = svg_pkg::RST_TIMEOUT_CYC,  // shortenable for simulation
  parameter int unsigned DIS_DELAY   = svg_pkg::DIS_DELAY_CYC     // power-down disable delay
) (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  // comparator results, asynchronous to the clock
  input  wire logic below_reset_thresh_in,   // supply below reset threshold
  input  wire logic below_battery_in,        // supply below backup_supply
  input  wire logic fail_sense_low_in,       // fail_sense_input below 1.25 V
  input  wire logic below_batt_margin_in,    // supply below backup_supply minus 1.2 V
  // watchdog side
  input  wire logic watchdog_fault_in,       // fault from watchdog timer
  input  wire logic watchdog_kick_input,     // kick pin, passed on unless in backup
  input  wire logic timing_select_input,     // timing select pin, passed on unless in backup
  output logic      watchdog_kick_out,       // kick toward watchdog timer
  output logic      timing_select_out,       // select toward timing source
  // chip-enable gate
  input  wire logic ce_n_in,                 // gated select input, active low
  output logic      ce_n_out,                // gated select output, active low
  output logic      ce_pass_en_out,          // high while transmission path on
  // status outputs
  output logic      reset_n_out,             // active-low reset
  output logic      reset_out,               // active-high reset
  output logic      low_line_n_out,          // supply-low flag, active low
  output logic      fail_warning_n_out,      // fail_warning_output, active low
  output logic      backup_active_output,    // high in battery-backup mode
  output logic      watchdog_fault_n_out,    // watchdog_fault_output, active low
  output logic      backup_mode_out          // battery-backup mode entered
);
  import svg_pkg::*;

  // two-stage synchronisers for all pin-side inputs
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] raw_w;
  logic [NSYNC-1:0] s1_q, s2_q;
  assign raw_w = {below_reset_thresh_in, below_battery_in, fail_sense_low_in,
                  below_batt_margin_in, watchdog_kick_input, timing_select_input, ce_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // first stage only feeds the second; reset value marks supply bad
      always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= raw_w[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  logic low_s, below_batt_s, fail_low_s, margin_s, kick_s, tsel_s, ce_s;
  assign {low_s, below_batt_s, fail_low_s, margin_s, kick_s, tsel_s, ce_s} = s2_q;

  // backup mode needs both comparators; watchdog fault is same clock, no sync
  logic backup_w;
  assign backup_w = low_s & below_batt_s;

  // reset timeout: counts while supply is good, resets hold until done
  logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic             rst_act_q, rst_act_d;
  always_comb begin
    rst_cnt_d = rst_cnt_q;
    rst_act_d = rst_act_q;
    if (low_s || watchdog_fault_in) begin
      rst_cnt_d = '0;
      rst_act_d = 1'b1;
    end else if (rst_act_q) begin
      if (rst_cnt_q >= CNT_W'(RST_TIMEOUT - 1)) begin
        rst_act_d = 1'b0;
      end else begin
        rst_cnt_d = rst_cnt_q + 1'b1;
      end
    end
  end
  // reset state registers; reset comes up asserted
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rst_cnt_q <= '0;
      rst_act_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      rst_act_q <= rst_act_d;
    end
  end

  // chip-enable gate state machine
  svg_gate_t          gate_q, gate_d;
  logic [DIS_CNT_W-1:0] dis_cnt_q, dis_cnt_d;
  always_comb begin
    gate_d    = gate_q;
    dis_cnt_d = dis_cnt_q;
    case (gate_q)
      SVG_GATE_PASS: begin
        dis_cnt_d = '0;
        if (rst_act_d) begin
          // a select already high closes at once, otherwise let the cycle finish
          gate_d = ce_s ? SVG_GATE_OFF : SVG_GATE_WAIT;
        end
      end
      SVG_GATE_WAIT: begin
        dis_cnt_d = dis_cnt_q + 1'b1;
        if (!rst_act_q) begin
          gate_d = SVG_GATE_PASS;
        end else if (ce_s || dis_cnt_q >= DIS_CNT_W'(DIS_DELAY - 1)) begin
          gate_d = SVG_GATE_OFF;
        end
      end
      SVG_GATE_OFF: begin
        dis_cnt_d = '0;
        // select activity ignored until reset ends
        if (!rst_act_q) begin
          gate_d = SVG_GATE_PASS;
        end
      end
      default: gate_d = SVG_GATE_OFF;
    endcase
  end
  // gate registers; come up closed as at power-up
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      gate_q    <= SVG_GATE_OFF;
      dis_cnt_q <= '0;
    end else begin
      gate_q    <= gate_d;
      dis_cnt_q <= dis_cnt_d;
    end
  end

  // output next values; fail compare feeds only its own pin
  logic ce_d, fail_n_d, batt_d, wdf_n_d, kick_d, tsel_d;
  always_comb begin
    ce_d     = (gate_q == SVG_GATE_OFF) ? 1'b1 : ce_s;
    fail_n_d = ~fail_low_s;
    if (backup_w && margin_s) begin
      fail_n_d = 1'b0;
    end
    batt_d  = below_batt_s | backup_w;
    wdf_n_d = backup_w ? 1'b1 : ~watchdog_fault_in;
    kick_d  = backup_w ? 1'b0 : kick_s;
    tsel_d  = backup_w ? 1'b0 : tsel_s;
  end
  // output flops
  logic ce_q, fail_n_q, batt_q, wdf_n_q, kick_q, tsel_q, low_q, bk_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ce_q     <= 1'b1;
      fail_n_q <= 1'b0;
      batt_q   <= 1'b0;
      wdf_n_q  <= 1'b1;
      kick_q   <= 1'b0;
      tsel_q   <= 1'b0;
      low_q    <= 1'b0;
      bk_q     <= 1'b0;
    end else begin
      ce_q     <= ce_d;
      fail_n_q <= fail_n_d;
      batt_q   <= batt_d;
      wdf_n_q  <= wdf_n_d;
      kick_q   <= kick_d;
      tsel_q   <= tsel_d;
      low_q    <= ~low_s;
      bk_q     <= backup_w;
    end
  end

  assign ce_n_out             = ce_q;
  assign ce_pass_en_out       = (gate_q != SVG_GATE_OFF);
  assign reset_n_out          = ~rst_act_q;
  assign reset_out            = rst_act_q;
  assign low_line_n_out       = low_q;
  assign fail_warning_n_out   = fail_n_q;
  assign backup_active_output = batt_q;
  assign watchdog_fault_n_out = wdf_n_q;
  assign watchdog_kick_out    = kick_q;
  assign timing_select_out    = tsel_q;
  assign backup_mode_out      = bk_q;

  // cycles spent waiting, helper for the disable delay check only
  logic [DIS_CNT_W-1:0] wait_len_q, wait_len_d;
  always_comb begin
    wait_len_d = (gate_q == SVG_GATE_WAIT) ? wait_len_q + 1'b1 : '0;
  end
  // helper register; a delay range would unroll too far at the real delay
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wait_len_q <= '0;
    end else begin
      wait_len_q <= wait_len_d;
    end
  end

  // checks
  chk_off_forces_high: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    gate_q == SVG_GATE_OFF |=> ce_n_out) else $error("select out not high while off");
  chk_reset_closes_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rst_act_q |-> gate_q != SVG_GATE_PASS) else $error("gate open during reset");
  chk_wait_bounded: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    gate_q == SVG_GATE_WAIT |-> wait_len_q < DIS_CNT_W'(DIS_DELAY))
    else $error("disable delay overran");
  chk_pass_follows: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    gate_q == SVG_GATE_PASS |=> ce_n_out == $past(ce_s)) else $error("select not passed");
  chk_low_line: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    low_s |=> !low_line_n_out) else $error("low-line not low");
  chk_low_resets: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    low_s |=> reset_out && !reset_n_out) else $error("reset not asserted");
  chk_backup_batt: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    backup_w |=> backup_active_output && watchdog_fault_n_out && !watchdog_kick_out && !timing_select_out)
    else $error("backup outputs wrong");
  chk_batt_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !below_batt_s |=> !backup_active_output) else $error("backup indicator high");
  chk_fail_follow: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !backup_w |=> fail_warning_n_out == !$past(fail_low_s)) else $error("fail warning wrong");
  chk_fail_forced: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    backup_w && margin_s |=> !fail_warning_n_out) else $error("fail warning not forced");
endmodule : svg_ctrl

// ---- test/svg_cs_model.sv ----
`timescale 1ns/1ps
// processor chip-select logic facing the gate
module svg_cs_model (
  // clock
  input  wire logic sys_clk_in,
  // control from the bench
  input  wire logic toggle_in,  // busy select activity
  input  wire logic level_in,   // held select level
  // select toward the gate
  output logic      ce_n_out
);
  logic tgl_q = 1'b0;  // toggle phase
  // flips each falling edge so a blocked gate is really tried
  always @(negedge sys_clk_in) tgl_q <= toggle_in ? ~tgl_q : 1'b0;
  assign ce_n_out = toggle_in ? tgl_q : level_in;
endmodule : svg_cs_model

// ---- test/svg_ctrl_bench.sv ----
`timescale 1ns/1ps
module svg_ctrl_bench;
  import svg_pkg::*;
  localparam int unsigned RT = 50;  // short reset timeout
  localparam int unsigned DD = 20;  // short disable delay
  typedef struct {int due; logic [10:0] v;} svg_note_t;
  // stimulus
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        sup_low    = 1'b0;  // supply below threshold
  logic        bat_low    = 1'b0;  // supply below battery
  logic        pf_low     = 1'b0;  // fail sense low
  logic        mgn_low    = 1'b0;  // below battery margin
  logic        wd_flt     = 1'b0;  // watchdog fault
  logic        kick       = 1'b0;
  logic        tsel       = 1'b0;
  logic        ce_lvl     = 1'b1;  // held select level
  logic        ce_tgl     = 1'b0;  // select toggling
  logic [15:0] seed       = 16'h6450;  // xorshift state
  // observation
  wire logic [10:0] obs;
  wire logic        ce_n_pin;
  int               cyc = 0;
  int               cmp_count = 0;
  int               n_mismatch = 0;
  svg_note_t        q[$];

  svg_cs_model cs_u (.sys_clk_in(sys_clk_in), .toggle_in(ce_tgl), .level_in(ce_lvl), .ce_n_out(ce_n_pin));
  svg_ctrl #(.RST_TIMEOUT(RT), .DIS_DELAY(DD)) dut_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .below_reset_thresh_in(sup_low), .below_battery_in(bat_low),
    .fail_sense_low_in(pf_low), .below_batt_margin_in(mgn_low),
    .watchdog_fault_in(wd_flt), .watchdog_kick_input(kick), .timing_select_input(tsel),
    .watchdog_kick_out(obs[3]), .timing_select_out(obs[2]),
    .ce_n_in(ce_n_pin), .ce_n_out(obs[1]), .ce_pass_en_out(obs[0]),
    .reset_n_out(obs[10]), .reset_out(obs[9]), .low_line_n_out(obs[8]),
    .fail_warning_n_out(obs[7]), .backup_active_output(obs[6]),
    .watchdog_fault_n_out(obs[5]), .backup_mode_out(obs[4]));

  initial forever #5 sys_clk_in = ~sys_clk_in;

  // expected outputs from the current pins; ra = reset held, off = gate closed
  function automatic logic [10:0] model(logic ra, logic off);
    logic bk;
    bk = sup_low & bat_low;
    return {~ra, ra, ~sup_low, ~(pf_low | (bk & mgn_low)), bat_low | bk,
            bk | ~wd_flt, bk, kick & ~bk, tsel & ~bk, off | ce_lvl, ~off};
  endfunction : model

  function automatic logic [15:0] xs(logic [15:0] s);
    s ^= s << 7;
    s ^= s >> 9;
    s ^= s << 8;
    return s;
  endfunction : xs

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp(string nm, logic [10:0] exp, logic [10:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  // note an expectation due dly edges on, then wait for the watcher
  task automatic chk(int dly, logic ra, logic off);
    int n;
    q.push_back('{cyc + dly, model(ra, off)});
    n = 0;
    while (q.size() > 0 && n < 2000) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (q.size() > 0) begin
      n_mismatch++;  // a note never consumed counts as a mismatch
      wrap_up();
    end else begin
      @(negedge sys_clk_in);
    end
  endtask : chk

  // watcher: settled outputs against the oldest due note
  initial forever begin
    @(posedge sys_clk_in);
    #2;
    cyc++;
    if (q.size() > 0 && q[0].due <= cyc) begin
      cmp("outputs", q[0].v, obs);
      void'(q.pop_front());
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    ce_tgl = 1'b1;
    chk(10, 1'b1, 1'b1);
    ce_tgl = 1'b0;
    chk(RT, 1'b0, 1'b0);
    $display("test power_up done");
    repeat (30) begin
      seed = xs(seed);
      {bat_low, pf_low, mgn_low, kick, tsel, ce_lvl} = seed[5:0];
      chk(4, 1'b0, 1'b0);
    end
    $display("test pass_through done");
    bat_low = 1'b0;
    sup_low = 1'b1;
    ce_lvl = 1'b0;
    chk(4, 1'b1, 1'b0);
    chk(DD - 3, 1'b1, 1'b0);
    chk(1, 1'b1, 1'b1);
    sup_low = 1'b0;
    chk(RT + 2, 1'b0, 1'b1);
    chk(4, 1'b0, 1'b0);
    sup_low = 1'b1;
    chk(4, 1'b1, 1'b0);
    ce_lvl = 1'b1;
    chk(4, 1'b1, 1'b1);
    $display("test power_down done");
    {bat_low, wd_flt, kick, tsel, pf_low, mgn_low} = 6'h3d;
    chk(4, 1'b1, 1'b1);
    mgn_low = 1'b0;
    chk(4, 1'b1, 1'b1);
    pf_low = 1'b1;
    chk(4, 1'b1, 1'b1);
    bat_low = 1'b0;
    chk(4, 1'b1, 1'b1);
    $display("test backup done");
    {sup_low, wd_flt, ce_lvl} = 3'h0;
    chk(RT + 6, 1'b0, 1'b0);
    wd_flt = 1'b1;
    chk(4, 1'b1, 1'b0);
    chk(DD, 1'b1, 1'b1);
    $display("test watchdog done");
    wrap_up();
  end
endmodule : svg_ctrl_bench
